/* File: shared/osc_ctrl_pkg.sv */
// Shared constants for the oscillator enable, ready and fail-safe monitor block
package osc_ctrl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [10:0] IDX_ACTIVE_TUNING   = 11'h0ac;
  localparam logic [10:0] IDX_REQUEST_SELECT  = 11'h0ad;
  localparam logic [10:0] IDX_CURRENT_SELECT  = 11'h0ae;
  localparam logic [10:0] IDX_SWITCH_CONTROL  = 11'h0af;
  localparam logic [10:0] IDX_FAST_TRIM       = 11'h0b0;
  localparam logic [10:0] IDX_FAST_FREQUENCY  = 11'h0b1;
  localparam logic [10:0] IDX_READY_FLAGS     = 11'h0b2;
  localparam logic [10:0] IDX_FORCE_ENABLE    = 11'h0b3;
  localparam logic [10:0] IDX_FAILSAFE        = 11'h458;

  // Address decode slicing
  localparam int          IDX_LSB             = 2;
  localparam int          IDX_MSB             = 12;
  localparam int          ADDR_TOP_LSB        = 13;

  // Force enable and ready flag positions (shared layout)
  localparam int          BIT_EXTERNAL        = 7;
  localparam int          BIT_FAST            = 6;
  localparam int          BIT_MID             = 5;
  localparam int          BIT_SLOW            = 4;
  localparam int          BIT_SECONDARY       = 3;
  localparam int          BIT_ADC_RC          = 2;
  localparam int          BIT_UNUSED          = 1;
  localparam int          BIT_PLL             = 0;
  localparam int          SRC_LOW             = 2;
  localparam int          SRC_HIGH            = 7;
  localparam logic [7:0]  FORCE_MASK          = 8'hfd;
  localparam logic [7:0]  FORCE_RESET         = 8'h00;
  localparam logic [7:0]  READY_RESET         = 8'h00;

  // Fail-safe control and status layout
  localparam int          BIT_SEC_INJECT      = 5;
  localparam int          BIT_SEC_FAIL        = 4;
  localparam int          BIT_PRI_INJECT      = 3;
  localparam int          BIT_PRI_FAIL        = 2;
  localparam int          BIT_SYS_INJECT      = 1;
  localparam int          BIT_SYS_FAIL        = 0;
  localparam int          FAILSAFE_W          = 6;
  localparam logic [5:0]  FAILSAFE_RESET      = 6'h00;

  // Monitor channel order
  localparam int          MON_SYS             = 0;
  localparam int          MON_PRI             = 1;
  localparam int          MON_SEC             = 2;
  localparam int          MON_N               = 3;

  // Frequency selection and secondary power select
  localparam int          FREQ_W              = 4;
  localparam logic [3:0]  FREQ_RESET          = 4'h0;
  localparam int          BIT_SEC_POWER       = 6;

  // Monitor time-out in reference edges
  localparam int          REF_TIMEOUT_EDGES   = 8;

endpackage

/* File: design/clock_watch.sv */
// One fail-safe monitor channel: edge watch against a reference tick
`timescale 1ns/1ps
`default_nettype none

module clock_watch
  import osc_ctrl_pkg::*;
#(
  parameter int TIMEOUT = REF_TIMEOUT_EDGES
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Monitored clock, already gated, asynchronous
  input  wire logic mon_pin,
  // Reference tick, one cycle
  input  wire logic ref_edge,
  // Failure, one cycle
  output logic      fail_pulse
);

  localparam int CW = $clog2(TIMEOUT + 1);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          s3;
    logic [CW-1:0] cnt;
    logic          failed;
    logic          pulse;
  } watch_s;

  watch_s st_ff;
  watch_s nxt_st;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.s1    = mon_pin;
    nxt_st.s2    = st_ff.s1;
    nxt_st.s3    = st_ff.s2;
    nxt_st.pulse = 1'b0;
    if (st_ff.s2 != st_ff.s3) begin
      nxt_st.cnt    = '0;
      nxt_st.failed = 1'b0;
    end else if (ref_edge && !st_ff.failed) begin
      // Report once per outage, not on every tick
      if (st_ff.cnt == CW'(TIMEOUT - 1)) begin
        nxt_st.failed = 1'b1;
        nxt_st.pulse  = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fail_pulse = st_ff.pulse;

endmodule

`default_nettype wire

/* File: design/osc_enable_ready_failsafe.sv */
// Oscillator force enables, ready flags and fail-safe monitor with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none

module osc_enable_ready_failsafe
  import osc_ctrl_pkg::*;
#(
  parameter int TIMEOUT = REF_TIMEOUT_EDGES
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Peripheral clock requests, same clock domain, bit per source
  input  wire logic [7:0]        periph_req,
  // Raw oscillator ready and PLL lock, asynchronous
  input  wire logic [7:0]        osc_ready_raw,
  // Monitored clocks and monitor reference, asynchronous
  input  wire logic              sys_clock_mon,
  input  wire logic              primary_clock_mon,
  input  wire logic              secondary_clock_mon,
  input  wire logic              ref_clock_mon,
  // Oscillator run enables
  output logic                   external_osc_run,
  output logic                   fast_internal_run,
  output logic                   mid_internal_run,
  output logic                   slow_internal_run,
  output logic                   secondary_osc_run,
  output logic                   adc_rc_run,
  // Oscillator settings
  output logic [FREQ_W-1:0]      fast_osc_frequency,
  output logic                   secondary_power_select,
  // Peripheral external clock path
  output logic                   pll_run,
  output logic                   periph_clock_use_pll,
  // Status
  output logic                   adc_rc_ready,
  output logic                   pll_ready_flag,
  output logic [FAILSAFE_W-1:0]  failsafe_state
);

  typedef struct packed {
    logic [7:0]            force_on;
    logic [FAILSAFE_W-1:0] failsafe;
    logic [FREQ_W-1:0]     freq;
    logic                  sec_power;
    logic [7:0]            run;
    logic [7:0]            rdy_s1;
    logic [7:0]            rdy_s2;
    logic [7:0]            ready;
    logic                  ref_s1;
    logic                  ref_s2;
    logic                  ref_s3;
    logic                  wr_pend;
    logic [10:0]           wr_idx;
    logic [31:0]           rdata;
  } ctrl_s;

  ctrl_s                  st_ff;
  ctrl_s                  nxt_st;
  logic [MON_N-1:0]       mon_pin;
  logic [MON_N-1:0]       mon_block;
  logic [MON_N-1:0]       mon_fail;
  logic                   ref_edge;
  logic                   addr_ok;
  logic [10:0]            addr_idx;
  logic                   addr_phase;
  logic [7:0]             src_run_nxt;
  logic [7:0]             src_ready_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Fail-safe monitor channels

  assign mon_pin[MON_SYS]   = sys_clock_mon;
  assign mon_pin[MON_PRI]   = primary_clock_mon;
  assign mon_pin[MON_SEC]   = secondary_clock_mon;

  // Gate ahead of the synchroniser so the monitor sees a dead clock
  assign mon_block[MON_SYS] = st_ff.failsafe[BIT_SYS_INJECT];
  assign mon_block[MON_PRI] = st_ff.failsafe[BIT_PRI_INJECT];
  assign mon_block[MON_SEC] = st_ff.failsafe[BIT_SEC_INJECT];

  assign ref_edge = st_ff.ref_s2 && !st_ff.ref_s3;

  genvar gi;
  generate
    for (gi = 0; gi < MON_N; gi++) begin : g_mon
      clock_watch #(
        .TIMEOUT (TIMEOUT)
      ) u_watch (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .mon_pin    (mon_pin[gi] && !mon_block[gi]),
        .ref_edge   (ref_edge),
        .fail_pulse (mon_fail[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Per-source run and ready

  genvar si;
  generate
    for (si = 0; si <= SRC_HIGH; si++) begin : g_src
      if (si >= SRC_LOW) begin : g_osc
        // Forced on, or started by a peripheral request
        assign src_run_nxt[si]   = st_ff.force_on[si] || periph_req[si];
        // Gated by run so a stale raw ready never shows
        assign src_ready_nxt[si] = st_ff.run[si] && st_ff.rdy_s2[si];
      end else if (si == BIT_PLL) begin : g_pll
        // PLL only spins when selected and the external path is wanted
        assign src_run_nxt[si]   = st_ff.force_on[si] && st_ff.run[BIT_EXTERNAL];
        assign src_ready_nxt[si] = st_ff.run[si] && st_ff.ready[BIT_EXTERNAL]
                                   && st_ff.rdy_s2[si];
      end else begin : g_gap
        // Unimplemented position never runs
        assign src_run_nxt[si]   = 1'b0;
        assign src_ready_nxt[si] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign addr_ok  = (haddr[31:ADDR_TOP_LSB] == '0) && (haddr[IDX_LSB-1:0] == '0);
  assign addr_idx = haddr[IDX_MSB:IDX_LSB];

  // Accepted address phase of any transfer
  assign addr_phase = hsel && hready && htrans[1];

  // Unimplemented or unmapped words read as zero
  function automatic logic [31:0] reg_read(input logic ok, input logic [10:0] idx,
                                           input ctrl_s s);
    logic [31:0] v;
    v = '0;
    if (ok) begin
      unique case (idx)
        IDX_READY_FLAGS:    v[7:0] = s.ready;
        IDX_FORCE_ENABLE:   v[7:0] = s.force_on & FORCE_MASK;
        IDX_FAILSAFE:       v[FAILSAFE_W-1:0] = s.failsafe;
        IDX_FAST_FREQUENCY: v[FREQ_W-1:0] = s.freq;
        IDX_SWITCH_CONTROL: v[BIT_SEC_POWER] = s.sec_power;
        default:            v = '0;
      endcase
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rdy_s1 = osc_ready_raw;
    nxt_st.rdy_s2 = st_ff.rdy_s1;
    nxt_st.ref_s1 = ref_clock_mon;
    nxt_st.ref_s2 = st_ff.ref_s1;
    nxt_st.ref_s3 = st_ff.ref_s2;

    // Data phase of a write
    if (st_ff.wr_pend) begin
      unique case (st_ff.wr_idx)
        IDX_FORCE_ENABLE:   nxt_st.force_on = hwdata[7:0] & FORCE_MASK;
        IDX_FAILSAFE:       nxt_st.failsafe = hwdata[FAILSAFE_W-1:0];
        IDX_FAST_FREQUENCY: nxt_st.freq = hwdata[FREQ_W-1:0];
        IDX_SWITCH_CONTROL: nxt_st.sec_power = hwdata[BIT_SEC_POWER];
        default:            nxt_st.force_on = st_ff.force_on;
      endcase
    end

    // Failure beats a same-cycle clear; hardware never clears
    if (mon_fail[MON_SEC]) begin
      nxt_st.failsafe[BIT_SEC_FAIL] = 1'b1;
    end
    if (mon_fail[MON_PRI]) begin
      nxt_st.failsafe[BIT_PRI_FAIL] = 1'b1;
    end
    if (mon_fail[MON_SYS]) begin
      nxt_st.failsafe[BIT_SYS_FAIL] = 1'b1;
    end

    // Run and ready come from the per-source slices
    nxt_st.run   = src_run_nxt;
    nxt_st.ready = src_ready_nxt;

    // Address phase; read value taken after any write lands
    nxt_st.wr_pend = 1'b0;
    if (addr_phase) begin
      nxt_st.wr_pend = hwrite && addr_ok;
      nxt_st.wr_idx  = addr_idx;
      nxt_st.rdata   = hwrite ? 32'h0000_0000 : reg_read(addr_ok, addr_idx, nxt_st);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff          <= '0;
      st_ff.force_on <= FORCE_RESET;
      st_ff.failsafe <= FAILSAFE_RESET;
      st_ff.freq     <= FREQ_RESET;
      st_ff.ready    <= READY_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero-wait slave, always OKAY
  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign hrdata                 = st_ff.rdata;

  assign external_osc_run       = st_ff.run[BIT_EXTERNAL];
  assign fast_internal_run      = st_ff.run[BIT_FAST];
  assign mid_internal_run       = st_ff.run[BIT_MID];
  assign slow_internal_run      = st_ff.run[BIT_SLOW];
  assign secondary_osc_run      = st_ff.run[BIT_SECONDARY];
  assign adc_rc_run             = st_ff.run[BIT_ADC_RC];
  assign fast_osc_frequency     = st_ff.freq;
  assign secondary_power_select = st_ff.sec_power;

  // Steers only the peripheral mux; system clock selection lives elsewhere
  assign pll_run                = st_ff.run[BIT_PLL];
  assign periph_clock_use_pll   = st_ff.force_on[BIT_PLL];

  assign adc_rc_ready           = st_ff.ready[BIT_ADC_RC];
  assign pll_ready_flag         = st_ff.ready[BIT_PLL];
  assign failsafe_state         = st_ff.failsafe;

endmodule

`default_nettype wire

/* File: tb/osc_partner.sv */
// Behavioural oscillators, lock, monitored clocks and monitor reference
`timescale 1ns/1ps
`default_nettype none
module osc_partner #(
  parameter int HALF = 4
) (
  // Clock and controls
  input  wire logic       hclk,
  input  wire logic [7:0] run,
  input  wire logic [2:0] stop,
  // Oscillator side
  output logic [7:0]      ready_raw,
  output logic [2:0]      mon,
  output logic            ref_clk
);
  logic [7:0] d1_ff;
  logic [7:0] d2_ff;
  int         cnt_ff;
  initial begin
    d1_ff = 8'h00;
    d2_ff = 8'h00;
    cnt_ff = 0;
    ready_raw = 8'h00;
    mon = 3'h0;
    ref_clk = 1'h0;
  end
  // Start-up takes a few cycles; a stopped source drops ready at once
  always @(posedge hclk) begin
    d1_ff <= run;
    d2_ff <= d1_ff & run;
    ready_raw <= d2_ff & run;
    cnt_ff <= cnt_ff + 1;
    // Dead clocks freeze at their level
    if (cnt_ff % HALF == HALF - 1) mon <= mon ^ ~stop;
    if (cnt_ff % (4 * HALF) == 4 * HALF - 1) ref_clk <= ~ref_clk;
  end
endmodule
`default_nettype wire

/* File: tb/osc_erf_chk.sv */
// Port-level assertions for the oscillator enable block
`timescale 1ns/1ps
`default_nettype none
module osc_erf_chk
  import osc_ctrl_pkg::*;
#(
  parameter int TIMEOUT = REF_TIMEOUT_EDGES
) (
  // Clock, reset, bus
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hready,
  // Requests and run enables
  input wire logic [7:0]            periph_req,
  input wire logic                  external_osc_run,
  input wire logic                  fast_internal_run,
  input wire logic                  mid_internal_run,
  input wire logic                  slow_internal_run,
  input wire logic                  secondary_osc_run,
  input wire logic                  adc_rc_run,
  input wire logic                  pll_run,
  // Status
  input wire logic                  adc_rc_ready,
  input wire logic                  pll_ready_flag,
  input wire logic [FAILSAFE_W-1:0] failsafe_state
);
  logic wr_fs_ff;
  // Data phase of a write to the fail-safe register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_fs_ff <= 1'h0;
    else wr_fs_ff <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_1160;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_ADC_READY: assert property (
    adc_rc_ready |-> $past(adc_rc_run) || $past(adc_rc_run, 2)) else $error("adc ready while off");
  AST_PLL_READY: assert property (
    pll_ready_flag |-> $past(pll_run) || $past(pll_run, 2)) else $error("pll ready while off");
  AST_EXT_REQ: assert property (
    periph_req[7] |=> external_osc_run) else $error("external request ignored");
  AST_FAST_REQ: assert property (
    periph_req[6] |-> ##1 fast_internal_run) else $error("fast request ignored");
  AST_MID_REQ: assert property (
    periph_req[5] ##1 periph_req[5] |-> mid_internal_run) else $error("mid request ignored");
  AST_SLOW_REQ: assert property (
    $rose(periph_req[4]) |=> slow_internal_run) else $error("slow request ignored");
  AST_SEC_REQ: assert property (
    periph_req[3] |=> secondary_osc_run) else $error("secondary request ignored");
  AST_ADC_REQ: assert property (
    periph_req[2] |=> adc_rc_run) else $error("adc request ignored");
  AST_PLL_SRC: assert property (
    pll_run |-> $past(external_osc_run)) else $error("pll runs without external source");
  AST_STICKY: assert property (
    |($past(failsafe_state) & ~failsafe_state & 6'h15) |-> $past(wr_fs_ff) || $past(wr_fs_ff, 2))
    else $error("failure flag cleared without write");
endmodule
bind osc_enable_ready_failsafe osc_erf_chk #(.TIMEOUT(TIMEOUT)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .periph_req(periph_req),
  .external_osc_run(external_osc_run), .fast_internal_run(fast_internal_run),
  .mid_internal_run(mid_internal_run), .slow_internal_run(slow_internal_run),
  .secondary_osc_run(secondary_osc_run), .adc_rc_run(adc_rc_run), .pll_run(pll_run),
  .adc_rc_ready(adc_rc_ready), .pll_ready_flag(pll_ready_flag),
  .failsafe_state(failsafe_state));
`default_nettype wire

/* File: tb/osc_enable_ready_failsafe_tb.sv */
// Self-checking bench for the oscillator enable, ready and fail-safe block
`timescale 1ns/1ps
`default_nettype none
module osc_enable_ready_failsafe_tb;
  import osc_ctrl_pkg::*;
  localparam int TMO = 2;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [7:0]  periph_req = 8'h00;
  logic [2:0]  stop = 3'h0;
  logic        hreadyout, hresp, ref_clk, ext_r, fast_r, mid_r, slow_r, sec_r, adc_r;
  logic        pll_run, sec_pwr, use_pll, adc_rc_ready, pll_ready_flag;
  logic [31:0] hrdata;
  logic [7:0]  ready_raw;
  logic [2:0]  mon;
  logic [3:0]  fast_freq;
  logic [5:0]  fs_state;
  int          error_cnt = 0;
  int          n_checks = 0;
  wire         hready = hreadyout;
  wire [7:0]   runs = {ext_r, fast_r, mid_r, slow_r, sec_r, adc_r, 1'h0, pll_run};
  always #50 hclk = ~hclk;
  osc_enable_ready_failsafe #(.TIMEOUT(TMO)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .periph_req(periph_req), .osc_ready_raw(ready_raw),
    .sys_clock_mon(mon[0]), .primary_clock_mon(mon[1]), .secondary_clock_mon(mon[2]),
    .ref_clock_mon(ref_clk), .external_osc_run(ext_r), .fast_internal_run(fast_r),
    .mid_internal_run(mid_r), .slow_internal_run(slow_r), .secondary_osc_run(sec_r),
    .adc_rc_run(adc_r), .fast_osc_frequency(fast_freq), .secondary_power_select(sec_pwr),
    .pll_run(pll_run), .periph_clock_use_pll(use_pll), .adc_rc_ready(adc_rc_ready),
    .pll_ready_flag(pll_ready_flag), .failsafe_state(fs_state));
  osc_partner partner_u (.hclk(hclk), .run(runs), .stop(stop), .ready_raw(ready_raw),
    .mon(mon), .ref_clk(ref_clk));
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // Bounded wait; a hang ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 20);
    if (hready !== 1'h1) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] rd;
    xfer(a, 1'h1, d, rd);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [7:0] exp);
    logic [31:0] rd;
    xfer(a, 1'h0, 8'h00, rd);
    chk(rd, {24'h00_0000, exp});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(32'h0000_02cc, 8'h00);
    rdchk(32'h0000_1160, 8'h00);
    rdchk(32'h0000_02c8, 8'h00);
    wr(32'h0000_02d0, 8'hff);
    rdchk(32'h0000_02d0, 8'h00);
    chk({24'h00_0000, runs}, 32'h0000_0000);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask
  task automatic t_force();
    int b;
    wr(32'h0000_02cc, 8'hff);
    rdchk(32'h0000_02cc, 8'hfd);
    chk({26'h000_0000, runs[7:2]}, 32'h0000_003f);
    chk({31'h0000_0000, use_pll}, 32'h0000_0001);
    wr(32'h0000_02c4, 8'h08);
    wr(32'h0000_02bc, 8'h40);
    tick(2);
    chk({28'h000_0000, fast_freq}, 32'h0000_0008);
    chk({31'h0000_0000, sec_pwr}, 32'h0000_0001);
    rdchk(32'h0000_02c4, 8'h08);
    rdchk(32'h0000_02bc, 8'h40);
    wr(32'h0000_02cc, 8'h00);
    // One request at a time: only its own source may run
    for (b = 2; b < 8; b++) begin
      @(posedge hclk);
      periph_req <= 8'h01 << b;
      tick(2);
      chk({26'h000_0000, runs[7:2]}, 32'h0000_0001 << (b - 2));
    end
    @(posedge hclk);
    periph_req <= 8'h00;
  endtask
  task automatic t_ready();
    wr(32'h0000_02cc, 8'h04);
    tick(12);
    chk({31'h0000_0000, adc_rc_ready}, 32'h0000_0001);
    rdchk(32'h0000_02c8, 8'h04);
    wr(32'h0000_02cc, 8'h81);
    tick(16);
    rdchk(32'h0000_02c8, 8'h81);
    chk({31'h0000_0000, pll_ready_flag}, 32'h0000_0001);
    chk({31'h0000_0000, pll_run}, 32'h0000_0001);
    wr(32'h0000_02cc, 8'h80);
    tick(8);
    chk({31'h0000_0000, pll_ready_flag}, 32'h0000_0000);
    chk({31'h0000_0000, adc_rc_ready}, 32'h0000_0000);
    chk({31'h0000_0000, use_pll}, 32'h0000_0000);
    chk({31'h0000_0000, pll_run}, 32'h0000_0000);
    wr(32'h0000_02cc, 8'h00);
  endtask
  // Pass 0 injects the fault, pass 1 really stops the clock
  task automatic t_fail();
    int p;
    int c;
    logic [7:0] exp;
    for (p = 0; p < 2; p++) begin
      for (c = 0; c < 3; c++) begin
        exp = (p == 0 ? 8'h03 : 8'h01) << (2 * c);
        @(posedge hclk);
        stop <= (p == 0) ? 3'h0 : 3'h1 << c;
        if (p == 0) wr(32'h0000_1160, 8'h02 << (2 * c));
        tick(160);
        if (p == 0) rdchk(32'h0000_1160, exp);
        else rdchk(32'h0000_1160, exp);
        chk({26'h000_0000, fs_state}, {24'h00_0000, exp});
        @(posedge hclk);
        stop <= 3'h0;
        tick(80);
        rdchk(32'h0000_1160, exp);
        wr(32'h0000_1160, 8'h00);
        tick(80);
        rdchk(32'h0000_1160, 8'h00);
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset();
    t_force();
    t_ready();
    t_fail();
    complete_run();
  end
endmodule
`default_nettype wire
